// >>> hdl/mphs_defines.vh
/*
 phasing sequencer constants: offsets, bit positions, codes, limits.
 assumes inclusion by bare name.
*/
`ifndef MPHS_DEFINES_VH
`define MPHS_DEFINES_VH
// ==========
// register byte offsets
`define MPHS_REG_CTRL 8'h00
`define MPHS_REG_STAT 8'h04
`define MPHS_REG_MAIN_SPR 8'h08
`define MPHS_REG_AUX_SPR 8'h0c
`define MPHS_REG_RESULT 8'h10
`define MPHS_REG_VIBDUR 8'h14
`define MPHS_REG_SPEED 8'h18
`define MPHS_REG_MAIN_POS 8'h1c
`define MPHS_REG_AUX_POS 8'h20
// ==========
// control bit positions
`define MPHS_CTL_VIB_CMD 0
`define MPHS_CTL_SW_DIS 1
`define MPHS_CTL_MAIN_FMT 2
`define MPHS_CTL_AUX_FMT 3
`define MPHS_CTL_FINE_REQ 4
`define MPHS_CTL_SAVE 5
`define MPHS_CTL_LESSW 6
`define MPHS_CTL_SAVE_VIB 7
// ==========
// status codes and limits
`define MPHS_RES_OK 16'h0000
`define MPHS_RES_ENABLE 16'h0002
`define MPHS_RES_NOTRDY 16'h0005
`define MPHS_RES_DEVIATE 16'h0006
`define MPHS_RES_OVER 16'h0007
`define MPHS_RES_IDLE 16'hffff
`define MPHS_VIB_DEV_MAX 16'd25
`define MPHS_VIB_MAX 16'd200
`define MPHS_VIB_INIT 16'd100
`define MPHS_SPR_RESET 16'h0400
`define MPHS_PLAIN_MAX 16'h7fff
`define MPHS_EXP_MAX 5'd18
// ==========
// bus responses
`define MPHS_RESP_OKAY 2'b00
`define MPHS_RESP_SLVERR 2'b10
`endif

// >>> hdl/mphs_enc_counter.v
/*
 quadrature counter with zero-mark pulse.
 assumes inputs synchronised to clk_sys_i.
*/
`timescale 1ns/1ps
`default_nettype none
module mphs_enc_counter #(
    parameter W = 32
) (
    input wire clk_sys_i,
    input wire rst_i,
    input wire a_i,
    input wire b_i,
    input wire z_i,
    input wire dir_neg_i,
    output reg [W-1:0] pos_o,
    output reg zero_o
);
    reg a_q;
    reg b_q;
    reg z_q;
    wire step;
    wire cw;
    assign step = (a_i ^ a_q) | (b_i ^ b_q);
    assign cw = (a_q ^ b_i) ^ dir_neg_i;
    // ==========
    // counting
    always @(posedge clk_sys_i) begin
        if (rst_i) begin
            a_q <= 1'b0;
            b_q <= 1'b0;
            z_q <= 1'b0;
            pos_o <= {W{1'b0}};
            zero_o <= 1'b0;
        end else begin
            a_q <= a_i;
            b_q <= b_i;
            z_q <= z_i;
            zero_o <= z_i & ~z_q;
            // RULE_19 clockwise counts up
            if (step) begin
                if (cw) begin
                    pos_o <= pos_o + {{(W-1){1'b0}}, 1'b1};
                end else begin
                    pos_o <= pos_o - {{(W-1){1'b0}}, 1'b1};
                end
            end
        end
    end
endmodule // mphs_enc_counter
`default_nettype wire

// >>> hdl/mphs_speed_loop.v
/*
 speed loop: demand = gain * (reference - measured) / 1024.
 assumes an update enable from the top.
*/
`timescale 1ns/1ps
`default_nettype none
module mphs_speed_loop (
    input wire clk_sys_i,
    input wire rst_i,
    input wire en_i,
    input wire signed [15:0] ref_i,
    input wire signed [15:0] meas_i,
    input wire [7:0] gain_i,
    output reg signed [16:0] err_o,
    output reg signed [15:0] demand_o
);
    wire signed [16:0] err_d;
    wire signed [25:0] prod;
    // RULE_20 reference minus measured
    assign err_d = {ref_i[15], ref_i} - {meas_i[15], meas_i};
    assign prod = err_o * $signed({1'b0, gain_i});
    always @(posedge clk_sys_i) begin
        if (rst_i) begin
            err_o <= 17'sh00000;
            demand_o <= 16'sh0000;
        end else if (en_i) begin
            err_o <= err_d;
            // RULE_20 error sets current
            demand_o <= prod[25:10];
        end
    end
endmodule // mphs_speed_loop
`default_nettype wire

// >>> hdl/mphs_top.v
/*
 motor phasing sequencer: vibration phasing, result code, done flag,
 fine phasing on the zero mark, absolute phasing store, encoders, speed loop.
 assumes an AXI4-Lite master on clk_sys_i and asynchronous encoder pins.
*/
// The implementer's own choices: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "mphs_defines.vh"
// Summary of operation
// RULE_01: setting the vibration phasing command bit starts the phasing procedure.
// RULE_02: software keeps disable 0, enable 1, fault 0 before commanding.
// RULE_03: successful procedure writes result code 0.
// RULE_04: result code 2 when hardware enable low or software disable set.
// RULE_05: result code 5 when in alarm or not ready during the procedure.
// RULE_06: code 6 when duration deviates over 25 from initial; value stays saveable.
// RULE_07: code 7 when computed duration exceeds 200.
// RULE_08: done flag set only on success; drive ok withheld while clear. The code also sets the done flag when the save bit stores absolute phasing.
// RULE_09: a saved duration is the initial value; one vibration if unchanged.
// RULE_10: steps per rev plain up to 32767, or exponential up to 2^18.
// RULE_11: sign of steps per rev gives feedback direction.
// RULE_12: software never saves parameters while drive is enabled.
// RULE_13: fine request bit makes correction at next zero mark.
// RULE_14: device clears fine request bit once correction is done.
// RULE_15: software requests fine phasing only after phasing, incremental encoder.
// RULE_16: reduced-wiring feedback does fine phasing automatically.
// RULE_17: software zeroes angle, disables, writes save bit, restarts for absolute.
// RULE_18: stored absolute phasing makes later start-ups skip the procedure.
// RULE_19: position counter counts up clockwise, down counterclockwise.
// RULE_20: speed error is reference minus measured and sets current demand.
// RULE_21: command bit returns to 0 when procedure ends; code valid then.
module mphs_top #(
    parameter VIB_UNIT = 16'd125
) (
    input wire clk_sys_i,
    input wire rst_i,
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire hardware_enable_flag_i,
    input wire [15:0] drive_fault_code_i,
    input wire inrush_ready_i,
    input wire [15:0] electrical_angle_value_i,
    input wire vib_settled_i,
    input wire [2:0] main_feedback_input_i,
    input wire [2:0] aux_feedback_input_i,
    input wire [15:0] speed_ref_i,
    input wire [7:0] speed_gain_i,
    output reg drive_ok_flag_o,
    output reg phasing_done_flag_o,
    output reg vibrate_o,
    output reg fine_correct_o,
    output reg [15:0] current_demand_o
);
    localparam ST_IDLE = 2'd0;
    localparam ST_VIB = 2'd1;
    localparam ST_EVAL = 2'd2;
    // ==========
    // pin synchronisers
    reg [5:0] pin_meta_q;
    reg [5:0] pin_sync_q;
    reg hwen_meta_q;
    reg hwen_q;
    always @(posedge clk_sys_i) begin
        if (rst_i) begin
            pin_meta_q <= 6'h00;
            pin_sync_q <= 6'h00;
            hwen_meta_q <= 1'b0;
            hwen_q <= 1'b0;
        end else begin
            pin_meta_q <= {aux_feedback_input_i, main_feedback_input_i};
            pin_sync_q <= pin_meta_q;
            hwen_meta_q <= hardware_enable_flag_i;
            hwen_q <= hwen_meta_q;
        end
    end
    // ==========
    // registers
    reg [7:0] ctrl_q;
    reg [15:0] main_spr_q;
    reg [15:0] aux_spr_q;
    reg [15:0] result_q;
    reg [15:0] vib_saved_q;
    reg saved_valid_q;
    reg abs_stored_q;
    reg [15:0] vib_calc_q;
    reg [1:0] state_q;
    reg [15:0] tick_q;
    reg [15:0] vib_cnt_q;
    reg [31:0] spr_main_eff;
    reg [31:0] spr_aux_eff;
    wire main_neg;
    wire aux_neg;
    wire [31:0] main_pos;
    wire [31:0] aux_pos;
    wire main_zero;
    wire aux_zero;
    wire signed [16:0] spd_err;
    wire signed [15:0] spd_dem;
    wire drive_enabled;
    wire not_ready;
    wire [15:0] vib_init;
    wire [15:0] vib_dev;
    assign drive_enabled = hwen_q & ~ctrl_q[`MPHS_CTL_SW_DIS];
    assign not_ready = (drive_fault_code_i != 16'h0000) | ~inrush_ready_i;
    // RULE_09 saved value as initial
    assign vib_init = saved_valid_q ? vib_saved_q : `MPHS_VIB_INIT;
    assign vib_dev = (vib_calc_q > vib_init) ? (vib_calc_q - vib_init) : (vib_init - vib_calc_q);
    // RULE_11 sign gives direction
    assign main_neg = main_spr_q[15];
    assign aux_neg = aux_spr_q[15];
    // RULE_10 plain or exponential format
    always @* begin
        spr_main_eff = 32'h00000000;
        spr_aux_eff = 32'h00000000;
        if (ctrl_q[`MPHS_CTL_MAIN_FMT]) begin
            spr_main_eff[(main_spr_q[4:0] > `MPHS_EXP_MAX) ? `MPHS_EXP_MAX : main_spr_q[4:0]] = 1'b1;
        end else begin
            spr_main_eff = {17'h00000, main_neg ? (~main_spr_q[14:0] + 15'h0001) : main_spr_q[14:0]};
        end
        if (ctrl_q[`MPHS_CTL_AUX_FMT]) begin
            spr_aux_eff[(aux_spr_q[4:0] > `MPHS_EXP_MAX) ? `MPHS_EXP_MAX : aux_spr_q[4:0]] = 1'b1;
        end else begin
            spr_aux_eff = {17'h00000, aux_neg ? (~aux_spr_q[14:0] + 15'h0001) : aux_spr_q[14:0]};
        end
    end
    // ==========
    // axi4-lite write path
    reg [7:0] awaddr_q;
    reg aw_have_q;
    reg [31:0] wdata_q;
    reg w_have_q;
    wire wr_go;
    assign wr_go = aw_have_q & w_have_q & ~s_axi_bvalid;
    // ==========
    // axi4-lite read path
    always @(posedge clk_sys_i) begin
        if (rst_i) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `MPHS_RESP_OKAY;
        end else begin
            s_axi_arready <= 1'b0;
            if (s_axi_rvalid & s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end else if (s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid) begin
                s_axi_arready <= 1'b1;
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= `MPHS_RESP_OKAY;
                case (s_axi_araddr)
                    `MPHS_REG_CTRL: s_axi_rdata <= {24'h000000, ctrl_q};
                    `MPHS_REG_STAT: s_axi_rdata <= {28'h0000000, abs_stored_q, drive_ok_flag_o,
                                                     phasing_done_flag_o, hwen_q};
                    `MPHS_REG_MAIN_SPR: s_axi_rdata <= {16'h0000, main_spr_q};
                    `MPHS_REG_AUX_SPR: s_axi_rdata <= {16'h0000, aux_spr_q};
                    `MPHS_REG_RESULT: s_axi_rdata <= {16'h0000, result_q};
                    `MPHS_REG_VIBDUR: s_axi_rdata <= {vib_saved_q, vib_calc_q};
                    `MPHS_REG_SPEED: s_axi_rdata <= {{15{spd_err[16]}}, spd_err};
                    `MPHS_REG_MAIN_POS: s_axi_rdata <= main_pos;
                    `MPHS_REG_AUX_POS: s_axi_rdata <= aux_pos;
                    default: begin
                        s_axi_rdata <= 32'h00000000;
                        s_axi_rresp <= `MPHS_RESP_SLVERR;
                    end
                endcase
            end
        end
    end
    // ==========
    // registers, bus writes and phasing sequencer
    always @(posedge clk_sys_i) begin
        if (rst_i) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `MPHS_RESP_OKAY;
            awaddr_q <= 8'h00;
            aw_have_q <= 1'b0;
            wdata_q <= 32'h00000000;
            w_have_q <= 1'b0;
            ctrl_q <= 8'h00;
            main_spr_q <= `MPHS_SPR_RESET;
            aux_spr_q <= `MPHS_SPR_RESET;
            result_q <= `MPHS_RES_IDLE;
            vib_saved_q <= 16'h0000;
            saved_valid_q <= 1'b0;
            abs_stored_q <= 1'b0;
            vib_calc_q <= 16'h0000;
            state_q <= ST_IDLE;
            tick_q <= 16'h0000;
            vib_cnt_q <= 16'h0000;
            phasing_done_flag_o <= 1'b0;
            drive_ok_flag_o <= 1'b0;
            vibrate_o <= 1'b0;
            fine_correct_o <= 1'b0;
        end else begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            fine_correct_o <= 1'b0;
            if (s_axi_awvalid & ~aw_have_q & ~s_axi_awready) begin
                s_axi_awready <= 1'b1;
                aw_have_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid & ~w_have_q & ~s_axi_wready) begin
                s_axi_wready <= 1'b1;
                w_have_q <= 1'b1;
                wdata_q <= s_axi_wdata & {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                                          {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
            end
            if (s_axi_bvalid & s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (wr_go) begin
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= `MPHS_RESP_OKAY;
                case (awaddr_q)
                    `MPHS_REG_CTRL: begin
                        ctrl_q <= wdata_q[7:0];
                        // RULE_17 store absolute phasing
                        if (wdata_q[`MPHS_CTL_SAVE] & ~drive_enabled & (electrical_angle_value_i == 16'h0000)) begin
                            abs_stored_q <= 1'b1;
                            phasing_done_flag_o <= 1'b1;
                        end
                        // RULE_06 calculated value can be saved
                        if (wdata_q[`MPHS_CTL_SAVE_VIB] & ~drive_enabled) begin
                            vib_saved_q <= vib_calc_q;
                            saved_valid_q <= 1'b1;
                        end
                    end
                    `MPHS_REG_MAIN_SPR: main_spr_q <= wdata_q[15:0];
                    `MPHS_REG_AUX_SPR: aux_spr_q <= wdata_q[15:0];
                    `MPHS_REG_STAT, `MPHS_REG_RESULT, `MPHS_REG_VIBDUR, `MPHS_REG_SPEED,
                    `MPHS_REG_MAIN_POS, `MPHS_REG_AUX_POS: s_axi_bresp <= `MPHS_RESP_OKAY;
                    default: s_axi_bresp <= `MPHS_RESP_SLVERR;
                endcase
                ctrl_q[`MPHS_CTL_SAVE] <= 1'b0;
                ctrl_q[`MPHS_CTL_SAVE_VIB] <= 1'b0;
            end
            // RULE_08 drive ok needs done flag
            drive_ok_flag_o <= phasing_done_flag_o & drive_enabled & ~not_ready;
            case (state_q)
                ST_IDLE: begin
                    // RULE_01 command starts procedure
                    if (ctrl_q[`MPHS_CTL_VIB_CMD] & ~wr_go) begin
                        // RULE_18 stored phasing skips
                        if (abs_stored_q) begin
                            result_q <= `MPHS_RES_OK;
                            ctrl_q[`MPHS_CTL_VIB_CMD] <= 1'b0;
                        // RULE_04 enable not correct
                        end else if (~drive_enabled) begin
                            result_q <= `MPHS_RES_ENABLE;
                            phasing_done_flag_o <= 1'b0;
                            ctrl_q[`MPHS_CTL_VIB_CMD] <= 1'b0;
                        // RULE_05 alarm or not ready
                        end else if (not_ready) begin
                            result_q <= `MPHS_RES_NOTRDY;
                            phasing_done_flag_o <= 1'b0;
                            ctrl_q[`MPHS_CTL_VIB_CMD] <= 1'b0;
                        end else begin
                            state_q <= ST_VIB;
                            phasing_done_flag_o <= 1'b0;
                            vibrate_o <= 1'b1;
                            tick_q <= 16'h0000;
                            vib_cnt_q <= 16'h0000;
                        end
                    end
                end
                ST_VIB: begin
                    if (tick_q == VIB_UNIT - 16'h0001) begin
                        tick_q <= 16'h0000;
                        vib_cnt_q <= vib_cnt_q + 16'h0001;
                    end else begin
                        tick_q <= tick_q + 16'h0001;
                    end
                    if (~drive_enabled | not_ready) begin
                        vibrate_o <= 1'b0;
                        state_q <= ST_IDLE;
                        ctrl_q[`MPHS_CTL_VIB_CMD] <= 1'b0;
                        result_q <= drive_enabled ? `MPHS_RES_NOTRDY : `MPHS_RES_ENABLE;
                    // RULE_09 single vibration of saved length
                    end else if (vib_settled_i | (vib_cnt_q > `MPHS_VIB_MAX) |
                                 (saved_valid_q & (vib_cnt_q == vib_saved_q))) begin
                        vibrate_o <= 1'b0;
                        vib_calc_q <= vib_cnt_q;
                        state_q <= ST_EVAL;
                    end
                end
                ST_EVAL: begin
                    state_q <= ST_IDLE;
                    // RULE_21 command returns to zero
                    ctrl_q[`MPHS_CTL_VIB_CMD] <= 1'b0;
                    // RULE_07 over maximum
                    if (vib_calc_q > `MPHS_VIB_MAX) begin
                        result_q <= `MPHS_RES_OVER;
                    // RULE_06 deviation over limit
                    end else if (vib_dev > `MPHS_VIB_DEV_MAX) begin
                        result_q <= `MPHS_RES_DEVIATE;
                    end else begin
                        // RULE_03 success code
                        result_q <= `MPHS_RES_OK;
                        // RULE_08 set only on success
                        phasing_done_flag_o <= 1'b1;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
            // RULE_13 fine correction at zero mark
            // RULE_16 reduced wiring automatic fine phasing
            if ((ctrl_q[`MPHS_CTL_FINE_REQ] | ctrl_q[`MPHS_CTL_LESSW]) & main_zero & phasing_done_flag_o) begin
                fine_correct_o <= 1'b1;
                // RULE_14 request cleared when done
                ctrl_q[`MPHS_CTL_FINE_REQ] <= 1'b0;
            end
        end
    end
    // ==========
    // encoders and speed loop
    mphs_enc_counter #(.W(32)) u_main_enc (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .a_i(pin_sync_q[0]),
        .b_i(pin_sync_q[1]),
        .z_i(pin_sync_q[2]),
        .dir_neg_i(main_neg),
        .pos_o(main_pos),
        .zero_o(main_zero)
    );
    mphs_enc_counter #(.W(32)) u_aux_enc (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .a_i(pin_sync_q[3]),
        .b_i(pin_sync_q[4]),
        .z_i(pin_sync_q[5]),
        .dir_neg_i(aux_neg),
        .pos_o(aux_pos),
        .zero_o(aux_zero)
    );
    reg [15:0] pos_prev_q;
    always @(posedge clk_sys_i) begin
        if (rst_i) begin
            pos_prev_q <= 16'h0000;
            current_demand_o <= 16'h0000;
        end else begin
            pos_prev_q <= main_pos[15:0];
            current_demand_o <= spd_dem;
        end
    end
    mphs_speed_loop u_speed (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .en_i(1'b1),
        .ref_i(speed_ref_i),
        .meas_i(main_pos[15:0] - pos_prev_q),
        .gain_i(speed_gain_i),
        .err_o(spd_err),
        .demand_o(spd_dem)
    );
endmodule // mphs_top
`default_nettype wire

// >>> bench/mphs_properties.sv
/*
 checker on mphs_top ports: bus handshakes, phasing, fine correction.
 assumes the bind below.
*/
`timescale 1ns/1ps
`default_nettype none
`include "mphs_defines.vh"
module mphs_properties (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic s_axi_awready,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic hardware_enable_flag_i,
    input wire logic [15:0] drive_fault_code_i,
    input wire logic inrush_ready_i,
    input wire logic drive_ok_flag_o,
    input wire logic phasing_done_flag_o,
    input wire logic vibrate_o,
    input wire logic fine_correct_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    // ==========
    // bus handshakes
    a_bvalid_held: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("bvalid dropped");
    a_rdata_held: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data not held");
    a_aw_pulse: assert property (s_axi_awready |=> !s_axi_awready)
        else $error("awready too long");
    a_write_resp: assert property (s_axi_awready && s_axi_wready |=> s_axi_bvalid)
        else $error("write response late");
    a_read_same: assert property (s_axi_arready |-> s_axi_rvalid)
        else $error("rvalid late");
    a_slverr_zero: assert property (s_axi_rvalid && s_axi_rresp == `MPHS_RESP_SLVERR |-> s_axi_rdata == 32'h0)
        else $error("slverr data");
    // ==========
    // phasing
    a_ok_needs_done: assert property (drive_ok_flag_o |-> $past(phasing_done_flag_o))
        else $error("ok without done");
    a_vib_enable: assert property ($rose(vibrate_o) |-> hardware_enable_flag_i)
        else $error("vibrate disabled");
    a_vib_ready: assert property ($rose(vibrate_o) |-> $past(drive_fault_code_i) == 16'h0 && $past(inrush_ready_i))
        else $error("vibrate not ready");
    a_fine_pulse: assert property (fine_correct_o |=> !fine_correct_o)
        else $error("fine too long");
    a_fine_done: assert property (fine_correct_o |-> phasing_done_flag_o)
        else $error("fine before done");
endmodule // mphs_properties
bind mphs_top mphs_properties mphs_properties_i (.*);
`default_nettype wire

// >>> bench/mphs_motor_model.sv
/*
 motor model: vibration settles after settle_i cycles; spin steps the encoder.
 assumes spin_i held four cycles per step.
*/
`timescale 1ns/1ps
`default_nettype none
module mphs_motor_model (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic vibrate_i,
    input wire logic [11:0] settle_i,
    input wire logic spin_i,
    input wire logic cw_i,
    output logic settled_o,
    output logic [2:0] fb_o
);
    logic [11:0] vib_q;
    logic [1:0] div_q;
    logic [5:0] ang_q;
    always @(posedge clk_sys_i) begin
        if (rst_i || !vibrate_i) vib_q <= 12'h0;
        else if (vib_q != settle_i) vib_q <= vib_q + 12'h1;
        if (rst_i || !spin_i) div_q <= 2'h0;
        else div_q <= div_q + 2'h1;
        if (rst_i) ang_q <= 6'h0;
        else if (spin_i && div_q == 2'h3) ang_q <= cw_i ? ang_q + 6'h1 : ang_q - 6'h1;
    end
    assign settled_o = vibrate_i && vib_q == settle_i;
    assign fb_o = {ang_q == 6'h20, ang_q[1] ^ ang_q[0], ang_q[1]};
endmodule // mphs_motor_model
`default_nettype wire

// >>> bench/mphs_top_tb.sv
/*
 bench for mphs_top.
 assumes motor model and bound checker.
*/
`timescale 1ns/1ps
`default_nettype none
`include "mphs_defines.vh"
module mphs_top_tb;
    logic clk_sys_i, rst_i, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic hwen, inrush, spin, cw, settled, drive_ok, done, vib, fine;
    logic [7:0] s_axi_awaddr, s_axi_araddr, gain;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [1:0] s_axi_bresp, s_axi_rresp, rr;
    logic [15:0] fault, angle, sref, demand;
    logic [11:0] settle;
    logic [2:0] fb;
    int num_errors, check_count, cyc, fine_cnt, vib_cnt, k;
    mphs_top #(.VIB_UNIT(16'd2)) mphs_top_i (.clk_sys_i, .rst_i, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .hardware_enable_flag_i(hwen),
        .drive_fault_code_i(fault), .inrush_ready_i(inrush), .electrical_angle_value_i(angle),
        .vib_settled_i(settled), .main_feedback_input_i(fb), .aux_feedback_input_i(3'h0),
        .speed_ref_i(sref), .speed_gain_i(gain), .drive_ok_flag_o(drive_ok),
        .phasing_done_flag_o(done), .vibrate_o(vib), .fine_correct_o(fine), .current_demand_o(demand));
    mphs_motor_model mphs_motor_model_i (.clk_sys_i, .rst_i, .vibrate_i(vib), .settle_i(settle),
        .spin_i(spin), .cw_i(cw), .settled_o(settled), .fb_o(fb));
    initial begin
        clk_sys_i = 1'b0;
        forever #4 clk_sys_i = ~clk_sys_i;
    end
    // ==========
    // tasks
    task report_and_stop;
        if (num_errors == 0 && check_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task chk(input logic [31:0] s, input logic [31:0] e);
        check_count++;
        if (s !== e) begin
            num_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk_sys_i);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clk_sys_i);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
    endtask
    task rd(input logic [7:0] a);
        @(posedge clk_sys_i);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clk_sys_i);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        rr = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task phase(input logic [31:0] c, input logic [31:0] e);
        wr(`MPHS_REG_CTRL, c);
        do rd(`MPHS_REG_CTRL); while (d[0] === 1'b1);
        rd(`MPHS_REG_RESULT);
        chk(d, e);
    endtask
    task spin_steps(input logic dir, input int n);
        cw <= dir;
        spin <= 1'b1;
        repeat (4 * n) @(posedge clk_sys_i);
        spin <= 1'b0;
        repeat (8) @(posedge clk_sys_i);
    endtask
    always @(posedge clk_sys_i) begin
        cyc <= cyc + 1;
        if (fine) fine_cnt <= fine_cnt + 1;
        if (vib) vib_cnt <= vib_cnt + 1;
        if (cyc == 60000) begin
            num_errors++;
            report_and_stop;
        end
    end
    // ==========
    // sequence
    initial begin
        {rst_i, inrush, cw} = 3'b111;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, hwen, spin} = 7'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
        {fault, angle, sref, gain, settle} = {16'h0, 16'h0001, 16'h0123, 8'h02, 12'd200};
        {num_errors, check_count, cyc, fine_cnt, vib_cnt} = 0;
        repeat (3) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        @(posedge clk_sys_i);
        rd(`MPHS_REG_MAIN_SPR);
        chk(d, 32'h400);
        rd(`MPHS_REG_AUX_SPR);
        chk(d, 32'h400);
        rd(8'h3c);
        chk({d[29:0], rr}, {30'h0, `MPHS_RESP_SLVERR});
        wr(`MPHS_REG_RESULT, 32'h0);
        rd(`MPHS_REG_RESULT);
        chk(d, 32'hffff);
        phase(32'h1, 32'h2);
        hwen <= 1'b1;
        phase(32'h3, 32'h2);
        inrush <= 1'b0;
        phase(32'h1, 32'h5);
        {inrush, fault} <= {1'b1, 16'h0011};
        phase(32'h1, 32'h5);
        {fault, settle} <= {16'h0, 12'd300};
        phase(32'h1, 32'h6);
        rd(`MPHS_REG_VIBDUR);
        chk({31'h0, d[15:0] > 16'd125}, 32'h1);
        settle <= 12'd500;
        phase(32'h1, 32'h7);
        chk({30'h0, drive_ok, done}, 32'h0);
        settle <= 12'd200;
        phase(32'h1, 32'h0);
        rd(`MPHS_REG_STAT);
        chk({drive_ok, d[3:0]}, 5'h17);
        wr(`MPHS_REG_CTRL, 32'h10);
        spin_steps(1'b1, 64);
        chk(fine_cnt, 1);
        rd(`MPHS_REG_CTRL);
        chk(d & 32'h10, 32'h0);
        rd(`MPHS_REG_MAIN_POS);
        chk(d, 32'd64);
        spin_steps(1'b0, 64);
        rd(`MPHS_REG_MAIN_POS);
        chk(d, 32'h0);
        wr(`MPHS_REG_MAIN_SPR, 32'h8400);
        spin_steps(1'b1, 16);
        rd(`MPHS_REG_MAIN_POS);
        chk(d, 32'hfffffff0);
        wr(`MPHS_REG_CTRL, 32'h40);
        spin_steps(1'b1, 64);
        chk(fine_cnt, 2);
        repeat (50) @(posedge clk_sys_i);
        rd(`MPHS_REG_SPEED);
        chk({15'h0, d[16:0]}, 32'h123);
        {hwen, angle} <= 17'h0;
        wr(`MPHS_REG_CTRL, 32'h20);
        hwen <= 1'b1;
        rd(`MPHS_REG_STAT);
        chk({31'h0, d[3]}, 32'h1);
        k = vib_cnt;
        phase(32'h1, 32'h0);
        chk(vib_cnt, k);
        report_and_stop;
    end
endmodule // mphs_top_tb
`default_nettype wire
